// *** hdl/upmps_top.sv ***
// Programmable memory machine pattern sequencer with APB registers
`timescale 1ns/100ps
`include "upmps_consts.svh"
// ====================================================================
module upmps_top
	import upmps_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	input  wire logic        bus_req_valid,
	input  wire logic [1:0]  bus_req_type,
	input  wire logic [2:0]  bus_req_bank,
	output      logic        bus_req_ready,
	input  wire logic        refresh_tick,
	input  wire logic        async_addr_strobe_n,
	input  wire logic [31:0] mem_data_in,
	output      logic [31:0] rd_data,
	output      logic [7:0]  mem_ctl,
	output      logic        transfer_ack_n,
	output      logic [1:0]  addr_mux
);
	// ====================================================================
	// Register interface
	logic [31:0]  ctrl_q, ctrl_d;
	logic [31:0]  wdata_q, wdata_d;
	logic [31:0]  prdata_q, prdata_d;
	logic         ram_we;
	logic [5:0]   ram_waddr;
	logic         exc_set;
	logic         async_mode, gp_line4_disable, start_addr_mux_bit;
	logic         apb_wr, apb_hit;
	upmps_state_e state_q, state_d;
	logic [5:0]   ptr_q, ptr_d;

	assign apb_wr  = psel && penable && pwrite;
	assign apb_hit = (paddr == `UPMPS_OFF_CTRL) || (paddr == `UPMPS_OFF_CMD) ||
		(paddr == `UPMPS_OFF_WDATA) || (paddr == `UPMPS_OFF_STAT);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !apb_hit;
	assign prdata  = prdata_q;
	assign async_mode         = ctrl_q[`UPMPS_CTRL_ASYNC];
	assign gp_line4_disable   = ctrl_q[`UPMPS_CTRL_GP4DIS];
	assign start_addr_mux_bit = ctrl_q[`UPMPS_CTRL_SAM];

	upmps_tmr_if tif ();

	always_comb begin
		ctrl_d    = ctrl_q;
		wdata_d   = wdata_q;
		prdata_d  = prdata_q;
		ram_we    = 1'b0;
		ram_waddr = pwdata[5:0];
		exc_set   = 1'b0;
		if (apb_wr && (paddr == `UPMPS_OFF_CTRL)) begin
			ctrl_d = pwdata;
		end
		if (apb_wr && (paddr == `UPMPS_OFF_WDATA)) begin
			wdata_d = pwdata;
		end
		if (apb_wr && (paddr == `UPMPS_OFF_CMD)) begin
			ram_we  = pwdata[`UPMPS_CMD_WRITE];
			exc_set = pwdata[`UPMPS_CMD_EXC];
		end
		// Read data latched in setup so it is steady for the access phase
		if (psel && !penable) begin
			case (paddr)
				`UPMPS_OFF_CTRL:  prdata_d = ctrl_q;
				`UPMPS_OFF_WDATA: prdata_d = wdata_q;
				`UPMPS_OFF_STAT:  prdata_d = {16'h0000, tif.busy, ptr_q, state_q};
				default:          prdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q   <= `UPMPS_CTRL_RST;
			wdata_q  <= 32'h0000_0000;
			prdata_q <= 32'h0000_0000;
		end else begin
			ctrl_q   <= ctrl_d;
			wdata_q  <= wdata_d;
			prdata_q <= prdata_d;
		end
	end

	// ====================================================================
	// Pattern store and bank timers
	logic [31:0] ram_rdata;
	upmps_word_s word;

	upmps_pat_ram u_ram (
		.pclk  (pclk),
		.wr_en (ram_we),
		.waddr (ram_waddr),
		.wdata (wdata_q),
		.raddr (ptr_q),
		.rdata (ram_rdata)
	);
	assign word = upmps_word_s'(ram_rdata);

	upmps_bank_tmr u_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.t       (tif)
	);

	// ====================================================================
	// Strobe synchroniser, first stage read only by the second
	logic as_meta_q, as_sync_q, as_asserted;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			as_meta_q <= 1'b1;
			as_sync_q <= 1'b1;
		end else begin
			as_meta_q <= async_addr_strobe_n;
			as_sync_q <= as_meta_q;
		end
	end
	assign as_asserted = !as_sync_q;

	// ====================================================================
	// Arbitration and sequencer
	logic        ref_pend_q, ref_pend_d, exc_pend_q, exc_pend_d;
	logic        force_q, force_d, first_q, first_d, ta_q, ta_d;
	logic [7:0]  ctl_q, ctl_d;
	logic [1:0]  mux_q, mux_d, amx_q, amx_d;
	logic [2:0]  bank_q, bank_d;
	logic        launch, enter_wait, tstart, ref_clr, exc_clr;
	upmps_pick_e pick;
	logic [5:0]  start_ptr;

	assign enter_wait = (state_q == UPMPS_RUN) && word.wait_enable_bit &&
		async_mode && as_asserted;

	always_comb begin
		pick = UPMPS_PICK_NONE;
		if (ref_pend_q) begin
			pick = UPMPS_PICK_REF;
		end else if (exc_pend_q) begin
			pick = UPMPS_PICK_EXC;
		end else if (bus_req_valid && !tif.busy[bus_req_bank]) begin
			pick = UPMPS_PICK_BUS;
		end
	end

	always_comb begin
		case (pick)
			UPMPS_PICK_REF: start_ptr = `UPMPS_START_REFRESH;
			UPMPS_PICK_EXC: start_ptr = `UPMPS_START_EXC;
			default: begin
				case (upmps_req_e'(bus_req_type))
					UPMPS_RD_SGL: start_ptr = `UPMPS_START_RD_SGL;
					UPMPS_RD_BST: start_ptr = `UPMPS_START_RD_BST;
					UPMPS_WR_SGL: start_ptr = `UPMPS_START_WR_SGL;
					default:      start_ptr = `UPMPS_START_WR_BST;
				endcase
			end
		endcase
	end

	always_comb begin
		state_d = state_q;
		ptr_d   = ptr_q;
		force_d = force_q;
		first_d = 1'b0;
		ta_d    = ta_q;
		ctl_d   = ctl_q;
		mux_d   = mux_q;
		amx_d   = amx_q;
		bank_d  = bank_q;
		launch  = 1'b0;
		tstart  = 1'b0;
		ref_clr = 1'b0;
		exc_clr = 1'b0;
		bus_req_ready = 1'b0;
		case (state_q)
			UPMPS_IDLE: begin
				ctl_d  = 8'hff;
				ta_d   = 1'b1;
				launch = 1'b1;
			end
			UPMPS_RUN: begin
				// Freeze on strobe and wait bit
				if (enter_wait) begin
					state_d = UPMPS_WAIT;
				end else begin
					ctl_d = force_q ? 8'hff : word.ctl;
					ta_d  = force_q ? 1'b1 : word.ta;
					mux_d = first_q ? {1'b0, start_addr_mux_bit} : amx_q;
					amx_d = word.addr_mux_field;
					if (word.disable_timer_trigger && (!async_mode || force_q)) begin
						tstart = 1'b1;
					end
					if (word.last) begin
						force_d = 1'b0;
						launch  = 1'b1;
					end else begin
						ptr_d = ptr_q + 6'h01;
					end
				end
			end
			UPMPS_WAIT: begin
				// Pointer frozen, resume at next word
				if (!as_asserted) begin
					force_d = 1'b1;
					ctl_d   = 8'hff;
					ta_d    = 1'b1;
					ptr_d   = ptr_q + 6'h01;
					state_d = UPMPS_RUN;
				end
			end
			default: begin
				state_d = UPMPS_IDLE;
			end
		endcase
		// Only a finished or idle machine may take a new pattern
		if (launch) begin
			if (pick != UPMPS_PICK_NONE) begin
				state_d = UPMPS_RUN;
				ptr_d   = start_ptr;
				first_d = 1'b1;
				ref_clr = (pick == UPMPS_PICK_REF);
				exc_clr = (pick == UPMPS_PICK_EXC);
				bus_req_ready = (pick == UPMPS_PICK_BUS);
				if (pick == UPMPS_PICK_BUS) begin
					bank_d = bus_req_bank;
				end
			end else begin
				state_d = UPMPS_IDLE;
			end
		end
		// Set wins over clear so no tick is lost
		ref_pend_d = refresh_tick || (ref_pend_q && !ref_clr);
		exc_pend_d = exc_set || (exc_pend_q && !exc_clr);
	end

	assign tif.start  = tstart;
	assign tif.bank   = bank_q;
	assign tif.period = ctrl_q[`UPMPS_CTRL_PER_LSB +: 8];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= UPMPS_IDLE;
			ptr_q      <= 6'h00;
			force_q    <= 1'b0;
			first_q    <= 1'b0;
			ta_q       <= 1'b1;
			ctl_q      <= 8'hff;
			mux_q      <= 2'h0;
			amx_q      <= 2'h0;
			bank_q     <= 3'h0;
			ref_pend_q <= 1'b0;
			exc_pend_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			ptr_q      <= ptr_d;
			force_q    <= force_d;
			first_q    <= first_d;
			ta_q       <= ta_d;
			ctl_q      <= ctl_d;
			mux_q      <= mux_d;
			amx_q      <= amx_d;
			bank_q     <= bank_d;
			ref_pend_q <= ref_pend_d;
			exc_pend_q <= exc_pend_d;
		end
	end

	assign mem_ctl        = ctl_q;
	assign transfer_ack_n = ta_q;
	assign addr_mux       = mux_q;

	// ====================================================================
	// Data sampling
	logic [31:0] pos_q, pos_d, neg_q, neg_d;
	logic        samp;
	assign samp = (state_q == UPMPS_RUN) && !enter_wait && word.sample;
	always_comb begin
		pos_d = (samp && !gp_line4_disable) ? mem_data_in : pos_q;
		neg_d = (samp && gp_line4_disable) ? mem_data_in : neg_q;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_q <= 32'h0000_0000;
		end else begin
			pos_q <= pos_d;
		end
	end
	// Half-cycle earlier capture trades setup margin for fewer cycles
	always_ff @(negedge pclk or negedge presetn) begin
		if (!presetn) begin
			neg_q <= 32'h0000_0000;
		end else begin
			neg_q <= neg_d;
		end
	end
	assign rd_data = gp_line4_disable ? neg_q : pos_q;

	// ====================================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_wait_held;
		(state_q == UPMPS_WAIT) && as_asserted;
	endsequence
	sequence s_released;
		(state_q == UPMPS_WAIT) && !as_asserted;
	endsequence
	property p_enter_wait;
		enter_wait |=> state_q == UPMPS_WAIT;
	endproperty
	a_enter_wait: assert property (p_enter_wait) else $error("no wait entry");
	property p_release_high;
		s_released |=> force_q && (ctl_q == 8'hff) && (state_q == UPMPS_RUN);
	endproperty
	a_release_high: assert property (p_release_high) else $error("not high");
	property p_force_until_last;
		(state_q == UPMPS_RUN) && force_q && !word.last |=> force_q && (ctl_q == 8'hff);
	endproperty
	a_force_until_last: assert property (p_force_until_last) else $error("drop early");
	property p_ta_hold;
		s_wait_held |=> $stable(ta_q) && $stable(ptr_q);
	endproperty
	a_ta_hold: assert property (p_ta_hold) else $error("ack or ptr moved");
	property p_disable_timer_trigger_gate;
		(state_q == UPMPS_RUN) && async_mode && !force_q |-> !tstart;
	endproperty
	a_disable_timer_trigger_gate: assert property (p_disable_timer_trigger_gate) else $error("early timer");
	property p_bank_block;
		bus_req_ready |-> !tif.busy[bus_req_bank];
	endproperty
	a_bank_block: assert property (p_bank_block) else $error("busy bank served");
	property p_no_gap;
		(state_q == UPMPS_RUN) && !enter_wait && word.last && (pick != UPMPS_PICK_NONE)
			|=> (state_q == UPMPS_RUN) && first_q;
	endproperty
	a_no_gap: assert property (p_no_gap) else $error("gap cycle");
	property p_start_rd;
		bus_req_ready && (bus_req_type == 2'h1) |=> ptr_q == 6'h08;
	endproperty
	a_start_rd: assert property (p_start_rd) else $error("bad burst read entry");
	property p_start_ref;
		launch && (pick == UPMPS_PICK_REF) |=> ptr_q == 6'h30;
	endproperty
	a_start_ref: assert property (p_start_ref) else $error("bad refresh entry");
	property p_mux_first;
		first_q && (state_q == UPMPS_RUN) && !enter_wait |=> mux_q == {1'b0, $past(ctrl_q[2])};
	endproperty
	a_mux_first: assert property (p_mux_first) else $error("first mux wrong");
	property p_mux_next;
		(state_q == UPMPS_RUN) && !enter_wait ##1 (state_q == UPMPS_RUN) && !first_q && !enter_wait
			|=> mux_q == $past(word.addr_mux_field, 2);
	endproperty
	a_mux_next: assert property (p_mux_next) else $error("mux not delayed");
	property p_one_pattern;
		bus_req_ready |-> launch && !ref_pend_q && !exc_pend_q;
	endproperty
	a_one_pattern: assert property (p_one_pattern) else $error("bad arbitration");
endmodule

// *** hdl/upmps_consts.svh ***
// Constants of the pattern sequencer
`ifndef UPMPS_CONSTS_SVH
`define UPMPS_CONSTS_SVH
`define UPMPS_OFF_CTRL      8'h00
`define UPMPS_OFF_CMD       8'h04
`define UPMPS_OFF_WDATA     8'h08
`define UPMPS_OFF_STAT      8'h0c
`define UPMPS_CTRL_RST      32'h0000_0000
`define UPMPS_CTRL_ASYNC    0
`define UPMPS_CTRL_GP4DIS   1
`define UPMPS_CTRL_SAM      2
`define UPMPS_CTRL_PER_LSB  8
`define UPMPS_CMD_WRITE     8
`define UPMPS_CMD_EXC       9
`define UPMPS_START_RD_SGL  6'h00
`define UPMPS_START_RD_BST  6'h08
`define UPMPS_START_WR_SGL  6'h18
`define UPMPS_START_WR_BST  6'h20
`define UPMPS_START_REFRESH 6'h30
`define UPMPS_START_EXC     6'h3c
`define UPMPS_WORDS         64
`define UPMPS_BANKS         8
`endif

// *** hdl/upmps_pkg.sv ***
// Types of the pattern sequencer
package upmps_pkg;
	typedef enum logic [1:0] {
		UPMPS_IDLE = 2'h0,
		UPMPS_RUN  = 2'h1,
		UPMPS_WAIT = 2'h3
	} upmps_state_e;
	typedef enum logic [1:0] {
		UPMPS_RD_SGL = 2'h0,
		UPMPS_RD_BST = 2'h1,
		UPMPS_WR_SGL = 2'h2,
		UPMPS_WR_BST = 2'h3
	} upmps_req_e;
	typedef enum logic [1:0] {
		UPMPS_PICK_NONE = 2'h0,
		UPMPS_PICK_REF  = 2'h1,
		UPMPS_PICK_EXC  = 2'h2,
		UPMPS_PICK_BUS  = 2'h3
	} upmps_pick_e;
	typedef struct packed {
		logic [16:0] rsvd;
		logic [7:0]  ctl;
		logic [1:0]  addr_mux_field;
		logic        sample;
		logic        ta;
		logic        disable_timer_trigger;
		logic        wait_enable_bit;
		logic        last;
	} upmps_word_s;
endpackage

// *** hdl/upmps_tmr_if.sv ***
// Link between sequencer and bank disable timers
`timescale 1ns/100ps
interface upmps_tmr_if;
	logic       start;
	logic [2:0] bank;
	logic [7:0] period;
	logic [7:0] busy;
	modport seq (output start, output bank, output period, input busy);
	modport tmr (input start, input bank, input period, output busy);
endinterface

// *** hdl/upmps_pat_ram.sv ***
// Pattern word array with one write and one read port
`timescale 1ns/100ps
`include "upmps_consts.svh"
module upmps_pat_ram (
	input  wire logic        pclk,
	input  wire logic        wr_en,
	input  wire logic [5:0]  waddr,
	input  wire logic [31:0] wdata,
	input  wire logic [5:0]  raddr,
	output      logic [31:0] rdata
);
	// Contents are undefined until software loads them
	logic [31:0] mem [0:`UPMPS_WORDS-1];

	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[waddr] <= wdata;
		end
	end

	// Read is combinational so a pattern end can launch the next word at once
	assign rdata = mem[raddr];
endmodule

// *** hdl/upmps_bank_tmr.sv ***
// Per-bank disable timers
`timescale 1ns/100ps
`include "upmps_consts.svh"
module upmps_bank_tmr (
	input  wire logic pclk,
	input  wire logic presetn,
	upmps_tmr_if.tmr  t
);
	genvar g;
	generate
		for (g = 0; g < `UPMPS_BANKS; g++) begin : g_bank
			logic [7:0] cnt_q;
			logic [7:0] cnt_d;
			always_comb begin
				cnt_d = cnt_q;
				if (t.start && (t.bank == 3'(g))) begin
					cnt_d = t.period;
				end else if (cnt_q != 8'h00) begin
					cnt_d = cnt_q - 8'h01;
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_q <= 8'h00;
				end else begin
					cnt_q <= cnt_d;
				end
			end
			assign t.busy[g] = (cnt_q != 8'h00);
		end
	endgenerate

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_tmr_busy;
		t.start && (t.period > 8'h01) |=> t.busy[$past(t.bank)];
	endproperty
	a_tmr_busy: assert property (p_tmr_busy) else $error("bank timer not started");
endmodule

// *** sim/upmps_mem_model.sv ***
// Memory device and asynchronous master stand-in for the pattern sequencer
`timescale 1ns/100ps
module upmps_mem_model (
	input  wire logic        pclk,
	input  wire logic        strobe_req,
	output      logic [31:0] mem_data_in,
	output      logic        async_addr_strobe_n
);
	logic [15:0] cnt;

	initial begin
		cnt = 16'h0000;
		mem_data_in = 32'h0000_0000;
		async_addr_strobe_n = 1'b1;
	end

	// ====================================================================
	// Data bus
	// Value differs per half cycle, so the sampling edge shows in the data
	always @(posedge pclk) begin
		cnt <= cnt + 16'h0001;
		mem_data_in <= {16'haaaa, cnt};
	end
	always @(negedge pclk) begin
		mem_data_in <= {16'h5555, cnt};
	end

	// ====================================================================
	// Asynchronous master strobe
	// Odd delay keeps the strobe unrelated to the clock phase
	always @(strobe_req) begin
		async_addr_strobe_n <= #37 ~strobe_req;
	end
endmodule

// *** sim/upmps_testbench.sv ***
// Self-checking bench of the pattern sequencer
`timescale 1ns/100ps
`include "upmps_consts.svh"
module testbench;
	import upmps_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ok;
	logic [7:0]  paddr, mem_ctl, c;
	logic [31:0] pwdata, prdata, mem_data_in, rd_data, rv;
	logic        bus_req_valid, bus_req_ready, refresh_tick, strobe_req;
	logic        async_addr_strobe_n, transfer_ack_n;
	logic [1:0]  bus_req_type, addr_mux;
	logic [2:0]  bus_req_bank;
	logic [7:0]  ctl_h[16];
	logic [1:0]  amx_h[16];
	logic        ack_h[16];
	logic [5:0]  starts[6];
	int          failures, checked, cyc, n, k;

	upmps_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .bus_req_valid, .bus_req_type, .bus_req_bank, .bus_req_ready,
		.refresh_tick, .async_addr_strobe_n, .mem_data_in, .rd_data, .mem_ctl,
		.transfer_ack_n, .addr_mux);
	upmps_mem_model mem (.pclk, .strobe_req, .mem_data_in, .async_addr_strobe_n);

	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			results();
		end
	end

	// ====================================================================
	// Tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x) begin
			failures++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Only the bench timeout ends this wait
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic ld(input logic [5:0] a, input logic [31:0] w);
		apb(1'b1, `UPMPS_OFF_WDATA, w);
		apb(1'b1, `UPMPS_OFF_CMD, 32'h0000_0100 | 32'(a));
	endtask
	function automatic logic [31:0] wd(input logic [7:0] cv, input logic [1:0] m,
		input logic [4:0] f);
		return {17'h0_0000, cv, m, f};
	endfunction
	// one bus request of type t to bank b, waits for ready up to 200 cycles
	task automatic req(input logic [1:0] t, input logic [2:0] b, input bit keep);
		bus_req_valid <= 1'b1;
		bus_req_type <= t;
		bus_req_bank <= b;
		n = 0;
		@(negedge pclk);
		while (bus_req_ready !== 1'b1 && n < 200) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 200)
			chk(1'b0, 1'b1);
		@(posedge pclk);
		if (!keep)
			bus_req_valid <= 1'b0;
	endtask
	task automatic see(input logic [7:0] v, input int lim);
		ok = 1'b0;
		for (int j = 0; j < lim && !ok; j++) begin
			@(negedge pclk);
			ok = (mem_ctl === v);
		end
		@(posedge pclk);
	endtask
	task automatic rec(input int m);
		for (int j = 0; j < m; j++) begin
			@(negedge pclk);
			ctl_h[j] = mem_ctl;
			amx_h[j] = addr_mux;
			ack_h[j] = transfer_ack_n;
		end
		@(posedge pclk);
	endtask
	task automatic results();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ====================================================================
	// Main sequence
	initial begin
		{pclk, presetn, psel, penable, pwrite, bus_req_valid, refresh_tick} = 7'h00;
		{paddr, pwdata, bus_req_type, bus_req_bank, strobe_req} = '0;
		starts = '{`UPMPS_START_RD_SGL, `UPMPS_START_RD_BST, `UPMPS_START_WR_SGL,
			`UPMPS_START_WR_BST, `UPMPS_START_REFRESH, `UPMPS_START_EXC};
		{failures, checked, cyc} = '0;
		void'($urandom(83136));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `UPMPS_OFF_CTRL, 32'h0);
		chk(rv, `UPMPS_CTRL_RST);
		chk(pready, 1'b1);
		apb(1'b0, 8'h10, 32'h0);
		chk(er, 1'b1);
		chk(rv, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 6; i++) begin
			c = {1'b0, 7'($urandom)};
			ld(starts[i], wd(c, 2'h0, 5'h01));
			if (i < 4)
				req(2'(i), 3'($urandom), 1'b0);
			else if (i == 4) begin
				refresh_tick <= 1'b1;
				@(posedge pclk);
				refresh_tick <= 1'b0;
			end else
				apb(1'b1, `UPMPS_OFF_CMD, 32'h0000_0200);
			see(c, 8);
			chk(ok, 1'b1);
		end
		$display("test start words done");
		apb(1'b1, `UPMPS_OFF_CTRL, 32'h0000_0004);
		ld(6'h00, wd(8'h11, 2'h2, 5'h00));
		ld(6'h01, wd(8'h22, 2'h1, 5'h01));
		ld(6'h18, wd(8'h33, 2'h0, 5'h01));
		fork
			begin
				req(2'h0, 3'h1, 1'b1);
				req(2'h2, 3'h2, 1'b0);
			end
			rec(12);
		join
		k = 0;
		while (k < 9 && ctl_h[k] !== 8'h11)
			k++;
		chk(ctl_h[k], 8'h11);
		chk(ctl_h[k + 1], 8'h22);
		chk(ctl_h[k + 2], 8'h33);
		chk(amx_h[k], 2'h1);
		chk(amx_h[k + 1], 2'h2);
		chk(amx_h[k + 2], 2'h1);
		$display("test back to back done");
		apb(1'b1, `UPMPS_OFF_CTRL, 32'h0000_1400);
		ld(6'h08, wd(8'h44, 2'h0, 5'h05));
		ld(6'h00, wd(8'h55, 2'h0, 5'h01));
		req(2'h1, 3'h3, 1'b1);
		req(2'h0, 3'h5, 1'b1);
		chk(n < 4, 1'b1);
		req(2'h0, 3'h3, 1'b0);
		chk(n > 8 && n < 30, 1'b1);
		$display("test disable timer done");
		apb(1'b1, `UPMPS_OFF_CTRL, 32'h0000_1401);
		// Wait word second, so the first word's outputs stand during the wait
		ld(6'h18, wd(8'h66, 2'h0, 5'h04));
		ld(6'h19, wd(8'h77, 2'h0, 5'h02));
		ld(6'h1a, wd(8'h88, 2'h0, 5'h05));
		strobe_req <= 1'b1;
		repeat (4) @(posedge pclk);
		req(2'h2, 3'h6, 1'b0);
		see(8'h66, 8);
		chk(ok, 1'b1);
		repeat (10) @(posedge pclk);
		@(negedge pclk);
		chk(mem_ctl, 8'h66);
		chk(transfer_ack_n, 1'b0);
		apb(1'b0, `UPMPS_OFF_STAT, 32'h0);
		chk(rv[7:0], {6'h19, 2'h3});
		chk(rv[14], 1'b0);
		strobe_req <= 1'b0;
		rec(10);
		k = 0;
		while (k < 9 && ctl_h[k] !== 8'hff)
			k++;
		chk(k < 7, 1'b1);
		for (int j = 0; j < 10; j++)
			chk({ctl_h[j], ack_h[j]}, j < k ? {8'h66, 1'b0} : {8'hff, 1'b1});
		apb(1'b0, `UPMPS_OFF_STAT, 32'h0);
		chk(rv[14], 1'b1);
		$display("test async wait done");
		for (int g = 0; g < 2; g++) begin
			apb(1'b1, `UPMPS_OFF_CTRL, 32'(g * 2));
			ld(6'h00, wd(8'h99, 2'h0, 5'h11));
			req(2'h0, 3'($urandom % 6), 1'b0);
			see(8'h99, 8);
			repeat (2) @(posedge pclk);
			chk(rd_data[31:16], g ? 16'haaaa : 16'h5555);
		end
		$display("test sampling edge done");
		results();
	end
endmodule
